/* pkg/trace_comp_defs.svh */
// Purpose: Constants for the trace address compression block
// Assumes: Included by the package and the design file
// Notes:   Definitions only
`ifndef TRACE_COMP_DEFS_SVH
`define TRACE_COMP_DEFS_SVH

`define TAC_ADDR_W       64
`define TAC_ISA_W        2
`define TAC_SIZE_W       4
`define TAC_SPEC_W       5
`define TAC_RS_CNT_W     4
`define TAC_ISA_DEFAULT  2'h0
`define TAC_ADDR_ZERO    64'h0
`define TAC_HIST_DEPTH   3
`define TAC_RS_DEPTH     3
`define TAC_RS_MAX       15
`define TAC_SHORT_W      16
`define TAC_FIFO_DEPTH   2'h2

`endif

/* pkg/trace_comp_pkg.sv */
// Purpose: Types for the trace address compression block
// Assumes: trace_comp_defs.svh gives the widths
// Notes:   Element in, packet out
`include "trace_comp_defs.svh"

package trace_comp_pkg;

  typedef enum logic [3:0] {
    EK_P0     = 4'h0,
    EK_TGT    = 4'h1,
    EK_SRC    = 4'h2,
    EK_EXC    = 4'h3,
    EK_TXF    = 4'h4,
    EK_RST    = 4'h5,
    EK_QTGT   = 4'h6,
    EK_INFO   = 4'h7,
    EK_ON     = 4'h8,
    EK_BBR    = 4'h9,
    EK_COMMIT = 4'hA
  } elem_kind_e;

  typedef enum logic [3:0] {
    PK_ATOM       = 4'h0,
    PK_ADDR_EXACT = 4'h1,
    PK_ADDR_SHORT = 4'h2,
    PK_ADDR_LONG  = 4'h3,
    PK_COMMIT     = 4'h4,
    PK_INFO       = 4'h5,
    PK_ON         = 4'h6,
    PK_TXF        = 4'h7,
    PK_RST        = 4'h8
  } pkt_kind_e;

  typedef struct packed {
    logic [`TAC_ADDR_W-1:0] addr;
    logic [`TAC_ISA_W-1:0]  isa;
  } addr_ent_s;

  typedef struct packed {
    elem_kind_e             kind;
    addr_ent_s              ent;
    logic [`TAC_SIZE_W-1:0] size;
    logic                   is_bl;
    logic                   is_ind;
    logic                   atom_e;
    logic                   final_e;
    logic                   q_implied;
    logic                   in_bbr;
    logic                   unknown;
    logic                   corrected;
  } elem_s;

  typedef struct packed {
    pkt_kind_e  kind;
    logic [1:0] idx;
  } form_s;

  typedef struct packed {
    pkt_kind_e  kind;
    elem_kind_e src;
    addr_ent_s  ent;
    logic [1:0] match_idx;
    logic       atom_e;
    logic       implied_commit;
    logic       rs_popped;
  } pkt_s;

endpackage

/* rtl/trace_address_compression.sv */
// Purpose: Address compression, implied commits and return stack for the trace byte stream
// Assumes: One element offered per cycle; inputs synchronous to core_clk_i
// Notes:   Two-entry buffer in front of the packet output
// Functional notes
// - Imply commit when speculation exceeds maximum depth
// - No commit packet for an implied commit
// - Keep last three explicit addresses
// - Push target, source, Q addresses to history
// - Exception pushes preferred return address
// - Unknown failure/reset address pushes zero, default
// - Target and Q pick exact or compressed
// - Source address picks exact or compressed
// - Exception address picks exact or compressed
// - Trace info zeroes all history entries
// - Return stack depth fixed, 0 to 15
// - Taken traced branch-with-link pushes return address
// - Push shifts entries down, new on top
// - Push when full drops oldest entry
// - Push follows initial prediction only
// - No push for Q-implied branch-with-link
// - No push inside branch broadcasting region
// - Pop when indirect target matches top
// - Pop suppresses target, shifts entries up
// - No pop for Q-implied indirect
// - Mispredict correction target never pops
// - Pop decided by final atom status
// - Clear stack on info, trace on, broadcast
// - Push before pop on combined instruction
`timescale 1ns/1ns
`include "trace_comp_defs.svh"

module trace_address_compression #(
  parameter int HIST_N   = `TAC_HIST_DEPTH,
  parameter int RS_DEPTH = `TAC_RS_DEPTH
) (
  // Clock and reset
  input  wire logic                   core_clk_i,
  input  wire logic                   nrst_i,
  // Configuration
  input  wire logic                   return_stack_enable_i,
  input  wire logic [`TAC_SPEC_W-1:0] max_speculation_depth_i,
  // Element stream from the processing element
  input  wire logic                   in_valid_i,
  output logic                        in_ready_o,
  input  trace_comp_pkg::elem_s       in_elem_i,
  // Packet stream to the trace output
  output logic                        out_valid_o,
  input  wire logic                   out_ready_i,
  output trace_comp_pkg::pkt_s        out_pkt_o,
  // Status
  output logic [`TAC_SPEC_W-1:0]      spec_count_o,
  output logic [`TAC_RS_CNT_W-1:0]    rs_count_o
);

  localparam int RS_N = (RS_DEPTH == 0) ? 1 : RS_DEPTH;
  localparam logic RS_PRESENT = (RS_DEPTH != 0);
  localparam logic [`TAC_RS_CNT_W-1:0] RS_FULL = `TAC_RS_CNT_W'(RS_DEPTH);

  typedef trace_comp_pkg::addr_ent_s [HIST_N-1:0] hist_t;
  typedef trace_comp_pkg::addr_ent_s [RS_N-1:0]   rstack_t;

  typedef struct packed {
    hist_t                              hist;
    rstack_t                            rs;
    logic [`TAC_RS_CNT_W-1:0]           rs_cnt;
    logic [`TAC_SPEC_W-1:0]             spec;
    trace_comp_pkg::pkt_s [1:0]         fifo;
    logic                               rd;
    logic [1:0]                         cnt;
  } st_s;

  st_s cur;
  st_s next_st;

  function automatic trace_comp_pkg::addr_ent_s zero_ent();
    trace_comp_pkg::addr_ent_s e;
    e.addr = `TAC_ADDR_ZERO;
    e.isa  = `TAC_ISA_DEFAULT;
    return e;
  endfunction

  // Newest address goes to entry 0, oldest falls off
  function automatic hist_t hist_push(hist_t h, trace_comp_pkg::addr_ent_s e);
    hist_t r;
    r = h;
    for (int i = HIST_N - 1; i > 0; i--) begin
      r[i] = h[i-1];
    end
    r[0] = e;
    return r;
  endfunction

  // Exact match against any entry, else compressed against the newest
  function automatic trace_comp_pkg::form_s addr_form(hist_t h, trace_comp_pkg::addr_ent_s e);
    trace_comp_pkg::form_s f;
    f.idx = 2'h0;
    if ((e.isa == h[0].isa) &&
        (e.addr[`TAC_ADDR_W-1:`TAC_SHORT_W] == h[0].addr[`TAC_ADDR_W-1:`TAC_SHORT_W])) begin
      f.kind = trace_comp_pkg::PK_ADDR_SHORT;
    end else begin
      f.kind = trace_comp_pkg::PK_ADDR_LONG;
    end
    for (int i = HIST_N - 1; i >= 0; i--) begin
      if (h[i] == e) begin
        f.kind = trace_comp_pkg::PK_ADDR_EXACT;
        f.idx  = 2'(i);
      end
    end
    return f;
  endfunction

  logic                      accept;
  logic                      emit;
  trace_comp_pkg::pkt_s      pkt;
  trace_comp_pkg::form_s     form;
  trace_comp_pkg::addr_ent_s ret_ent;
  logic                      do_push;
  logic                      do_pop;
  logic                      pop_out;
  logic [`TAC_SPEC_W-1:0]    spec_inc;

  assign in_ready_o   = (cur.cnt != `TAC_FIFO_DEPTH);
  assign accept       = in_valid_i && in_ready_o;
  assign out_valid_o  = (cur.cnt != 2'h0);
  assign out_pkt_o    = cur.fifo[cur.rd];
  assign pop_out      = out_valid_o && out_ready_i;
  assign spec_count_o = cur.spec;
  assign rs_count_o   = cur.rs_cnt;

  always_comb begin
    next_st  = cur;
    emit     = 1'b0;
    do_push  = 1'b0;
    do_pop   = 1'b0;
    spec_inc = cur.spec + `TAC_SPEC_W'(1);
    form     = addr_form(cur.hist, in_elem_i.ent);
    ret_ent.addr = in_elem_i.ent.addr + `TAC_ADDR_W'(in_elem_i.size);
    ret_ent.isa  = in_elem_i.ent.isa;
    pkt.kind           = trace_comp_pkg::PK_ATOM;
    pkt.src            = in_elem_i.kind;
    pkt.ent            = in_elem_i.ent;
    pkt.match_idx      = form.idx;
    pkt.atom_e         = in_elem_i.atom_e;
    pkt.implied_commit = 1'b0;
    pkt.rs_popped      = 1'b0;

    if (accept) begin
      case (in_elem_i.kind)
        trace_comp_pkg::EK_P0: begin
          emit = 1'b1;
          if (spec_inc > max_speculation_depth_i) begin
            pkt.implied_commit = 1'b1;
            next_st.spec       = cur.spec;
          end else begin
            next_st.spec = spec_inc;
          end
          // Push first so a combined instruction pops its own return address
          do_push = RS_PRESENT && return_stack_enable_i && in_elem_i.is_bl && in_elem_i.atom_e &&
                    !in_elem_i.q_implied && !in_elem_i.in_bbr;
          if (do_push) begin
            for (int i = RS_N - 1; i > 0; i--) begin
              next_st.rs[i] = cur.rs[i-1];
            end
            next_st.rs[0] = ret_ent;
            if (cur.rs_cnt != RS_FULL) begin
              next_st.rs_cnt = cur.rs_cnt + `TAC_RS_CNT_W'(1);
            end
          end
          if (in_elem_i.is_ind && in_elem_i.final_e) begin
            do_pop = RS_PRESENT && !in_elem_i.q_implied &&
                     (next_st.rs_cnt != `TAC_RS_CNT_W'(0)) &&
                     (next_st.rs[0] == in_elem_i.ent);
            if (do_pop) begin
              for (int i = 0; i < RS_N - 1; i++) begin
                next_st.rs[i] = next_st.rs[i+1];
              end
              next_st.rs[RS_N-1] = zero_ent();
              next_st.rs_cnt     = next_st.rs_cnt - `TAC_RS_CNT_W'(1);
              pkt.rs_popped      = 1'b1;
            end else begin
              pkt.kind     = form.kind;
              next_st.hist = hist_push(cur.hist, in_elem_i.ent);
            end
          end
        end
        trace_comp_pkg::EK_TGT, trace_comp_pkg::EK_QTGT: begin
          // Corrected targets and Q addresses never touch the stack
          emit         = 1'b1;
          pkt.kind     = form.kind;
          next_st.hist = hist_push(cur.hist, in_elem_i.ent);
        end
        trace_comp_pkg::EK_SRC: begin
          emit         = 1'b1;
          pkt.kind     = form.kind;
          next_st.hist = hist_push(cur.hist, in_elem_i.ent);
        end
        trace_comp_pkg::EK_EXC: begin
          emit         = 1'b1;
          pkt.kind     = form.kind;
          next_st.hist = hist_push(cur.hist, in_elem_i.ent);
        end
        trace_comp_pkg::EK_TXF, trace_comp_pkg::EK_RST: begin
          emit     = 1'b1;
          pkt.kind = (in_elem_i.kind == trace_comp_pkg::EK_TXF) ? trace_comp_pkg::PK_TXF
                                                                : trace_comp_pkg::PK_RST;
          if (in_elem_i.unknown) begin
            pkt.ent      = zero_ent();
            next_st.hist = hist_push(cur.hist, zero_ent());
          end else begin
            next_st.hist = hist_push(cur.hist, in_elem_i.ent);
          end
        end
        trace_comp_pkg::EK_INFO: begin
          emit     = 1'b1;
          pkt.kind = trace_comp_pkg::PK_INFO;
          for (int i = 0; i < HIST_N; i++) begin
            next_st.hist[i] = zero_ent();
          end
          next_st.rs_cnt = `TAC_RS_CNT_W'(0);
          next_st.spec   = `TAC_SPEC_W'(0);
        end
        trace_comp_pkg::EK_ON: begin
          emit           = 1'b1;
          pkt.kind       = trace_comp_pkg::PK_ON;
          next_st.rs_cnt = `TAC_RS_CNT_W'(0);
        end
        trace_comp_pkg::EK_BBR: begin
          next_st.rs_cnt = `TAC_RS_CNT_W'(0);
        end
        trace_comp_pkg::EK_COMMIT: begin
          // A commit already implied leaves nothing to resolve
          if (cur.spec != `TAC_SPEC_W'(0)) begin
            emit         = 1'b1;
            pkt.kind     = trace_comp_pkg::PK_COMMIT;
            next_st.spec = cur.spec - `TAC_SPEC_W'(1);
          end
        end
        default: begin
          emit = 1'b0;
        end
      endcase
    end

    if (emit) begin
      next_st.fifo[cur.rd ^ cur.cnt[0]] = pkt;
    end
    if (pop_out) begin
      next_st.rd = ~cur.rd;
    end
    next_st.cnt = cur.cnt + {1'b0, emit} - {1'b0, pop_out};
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cur <= '0;
    end else begin
      cur <= next_st;
    end
  end

  // Checks
  chk_spec_bound: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (accept && in_elem_i.kind == trace_comp_pkg::EK_P0 && $stable(max_speculation_depth_i)
      && cur.spec == max_speculation_depth_i) |=> (cur.spec == $past(cur.spec)))
    else $error("speculation count passed the maximum depth");

  chk_no_dup_commit: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (accept && in_elem_i.kind == trace_comp_pkg::EK_COMMIT && cur.spec == `TAC_SPEC_W'(0) && !pop_out)
      |=> (cur.cnt == $past(cur.cnt)))
    else $error("commit packet sent for an implied commit");

  chk_hist_target: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (accept && (in_elem_i.kind == trace_comp_pkg::EK_TGT || in_elem_i.kind == trace_comp_pkg::EK_SRC))
      |=> (cur.hist[0] == $past(in_elem_i.ent)) && (cur.hist[1] == $past(cur.hist[0])))
    else $error("address not pushed into history");

  chk_unknown_zero: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (accept && in_elem_i.unknown &&
      (in_elem_i.kind == trace_comp_pkg::EK_TXF || in_elem_i.kind == trace_comp_pkg::EK_RST))
      |=> (cur.hist[0].addr == `TAC_ADDR_ZERO) && (cur.hist[0].isa == `TAC_ISA_DEFAULT))
    else $error("unknown address not recorded as zero");

  chk_info_hist: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (accept && in_elem_i.kind == trace_comp_pkg::EK_INFO)
      |=> (cur.hist[HIST_N-1] == '0) && (cur.hist[0] == '0) && (cur.spec == '0))
    else $error("history not cleared by trace info");

  chk_rs_clear: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (accept && (in_elem_i.kind == trace_comp_pkg::EK_ON || in_elem_i.kind == trace_comp_pkg::EK_BBR))
      |=> (rs_count_o == `TAC_RS_CNT_W'(0)))
    else $error("return stack not cleared");

  chk_q_no_push: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (accept && in_elem_i.kind == trace_comp_pkg::EK_P0 &&
      (in_elem_i.q_implied || (in_elem_i.in_bbr && !in_elem_i.is_ind)))
      |=> (rs_count_o == $past(rs_count_o)))
    else $error("stack changed for a Q-implied or broadcast branch");

  chk_push_top: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (accept && do_push && !do_pop) |=> (cur.rs[0].addr == $past(ret_ent.addr))
      && (rs_count_o == (($past(rs_count_o) == RS_FULL) ? RS_FULL : $past(rs_count_o) + 4'h1)))
    else $error("return address push wrong");

  chk_pop_suppress: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (accept && do_pop) |-> ##1 (cur.fifo[$past(cur.rd ^ cur.cnt[0])].kind == trace_comp_pkg::PK_ATOM))
    else $error("popped target still sent as address");

  chk_fifo_hold: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (out_valid_o && !out_ready_i) |=> out_valid_o && $stable(out_pkt_o))
    else $error("packet output changed while stalled");

endmodule // trace_address_compression

/* tb/tac_analyzer_model.sv */
// Purpose: Far-side consumer of the compressed packet stream
// Assumes: Packets are taken at the rising edge where valid and ready are high
// Notes:   Stalls at random when stall_en_i is set
`timescale 1ns/1ns

module tac_analyzer_model (
  // Clock and reset
  input  wire logic                  core_clk_i,
  input  wire logic                  nrst_i,
  // Control
  input  wire logic                  stall_en_i,
  // Packet stream
  input  wire logic                  out_valid_i,
  output logic                       out_ready_o,
  input  trace_comp_pkg::pkt_s       out_pkt_i,
  // Taken packet, one cycle after the take
  output logic                       got_o,
  output trace_comp_pkg::pkt_s       got_pkt_o
);
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      out_ready_o <= 1'b0;
      got_o       <= 1'b0;
      got_pkt_o   <= '0;
    end else begin
      got_o       <= out_valid_i & out_ready_o;
      got_pkt_o   <= out_pkt_i;
      out_ready_o <= stall_en_i ? (($urandom % 3) != 0) : 1'b1;
    end
  end
endmodule // tac_analyzer_model

/* tb/trace_address_compression_tb_top.sv */
// Purpose: Self-checking bench for trace address compression
// Assumes: Return stack depth 3, history depth 3, speculation limit 4
// Notes:   Behavioural model predicts every packet
`timescale 1ns/1ns

module trace_address_compression_tb_top;
  import trace_comp_pkg::*;
  `define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fail_count++; \
    $display("FAIL %0t packet field mismatch", $time); end end

  logic core_clk_i, nrst_i, rse, in_valid_i, in_ready_o, out_valid_o, out_ready_i, got, stall;
  logic [4:0] max_spec, spec_count_o;
  logic [3:0] rs_count_o;
  elem_s      in_elem_i;
  pkt_s       out_pkt_o, got_pkt;
  int         fail_count, cmp_count, spec;
  addr_ent_s  hist [3];
  addr_ent_s  stk [$];
  pkt_s       expq [$];
  logic [63:0] pool [4] = '{64'h1004, 64'h1000, 64'h2345_0000, 64'h1004_1000};

  trace_address_compression #(.HIST_N(3), .RS_DEPTH(3)) i_trace_address_compression (
    .core_clk_i(core_clk_i), .nrst_i(nrst_i), .return_stack_enable_i(rse),
    .max_speculation_depth_i(max_spec), .in_valid_i(in_valid_i), .in_ready_o(in_ready_o),
    .in_elem_i(in_elem_i), .out_valid_o(out_valid_o), .out_ready_i(out_ready_i),
    .out_pkt_o(out_pkt_o), .spec_count_o(spec_count_o), .rs_count_o(rs_count_o));

  tac_analyzer_model i_tac_analyzer_model (
    .core_clk_i(core_clk_i), .nrst_i(nrst_i), .stall_en_i(stall), .out_valid_i(out_valid_o),
    .out_ready_o(out_ready_i), .out_pkt_i(out_pkt_o), .got_o(got), .got_pkt_o(got_pkt));

  initial begin
    core_clk_i = 1'b0;
    forever #20 core_clk_i = ~core_clk_i;
  end

  function automatic void hpush(addr_ent_s a);
    hist[2] = hist[1];
    hist[1] = hist[0];
    hist[0] = a;
  endfunction

  function automatic pkt_s aform(addr_ent_s a);
    pkt_s p;
    p = '0;
    p.ent = a;
    p.kind = PK_ADDR_LONG;
    if (a.addr[63:16] == hist[0].addr[63:16] && a.isa == hist[0].isa) p.kind = PK_ADDR_SHORT;
    for (int i = 2; i >= 0; i--) if (hist[i] == a) begin
      p.kind = PK_ADDR_EXACT;
      p.match_idx = 2'(i);
    end
    hpush(a);
    return p;
  endfunction

  task automatic model(elem_s e);
    pkt_s p;
    addr_ent_s r;
    bit emit;
    bit ic;
    p = '0;
    emit = 1'b1;
    case (e.kind)
      EK_P0: begin
        p.kind = PK_ATOM;
        if (spec + 1 > max_spec) p.implied_commit = 1'b1; else spec++;
        if (rse && e.is_bl && e.atom_e && !e.q_implied && !e.in_bbr) begin
          r.addr = e.ent.addr + 64'(e.size);
          r.isa = e.ent.isa;
          stk.push_front(r);
          if (stk.size() > 3) void'(stk.pop_back());
        end
        if (e.is_ind && e.final_e && !e.q_implied && stk.size() > 0 && stk[0] == e.ent) begin
          void'(stk.pop_front());
          p.rs_popped = 1'b1;
        end else if (e.is_ind && e.final_e) begin
          ic = p.implied_commit;
          p = aform(e.ent);
          p.implied_commit = ic;
        end
      end
      EK_TGT, EK_SRC, EK_EXC, EK_QTGT: p = aform(e.ent);
      EK_TXF, EK_RST: begin
        p.kind = e.kind == EK_TXF ? PK_TXF : PK_RST;
        hpush(e.unknown ? addr_ent_s'('0) : e.ent);
      end
      EK_INFO: begin
        p.kind = PK_INFO;
        hist = '{default: '0};
        stk.delete();
        spec = 0;
      end
      EK_ON: begin
        p.kind = PK_ON;
        stk.delete();
      end
      EK_COMMIT: if (spec != 0) begin
        p.kind = PK_COMMIT;
        spec--;
      end else emit = 1'b0;
      default: begin
        emit = 1'b0;
        stk.delete();
      end
    endcase
    if (emit) expq.push_back(p);
  endtask

  always @(posedge core_clk_i) if (got === 1'b1) begin
    if (expq.size() == 0) `CHK(1'b1, 1'b0)
    else begin
      `CHK(got_pkt.kind, expq[0].kind)
      `CHK(got_pkt.rs_popped, expq[0].rs_popped)
      `CHK(got_pkt.implied_commit, expq[0].implied_commit)
      if (expq[0].kind inside {PK_ADDR_EXACT, PK_ADDR_SHORT, PK_ADDR_LONG}) `CHK(got_pkt.ent, expq[0].ent)
      if (expq[0].kind == PK_ADDR_EXACT) `CHK(got_pkt.match_idx, expq[0].match_idx)
      void'(expq.pop_front());
    end
  end

  task automatic test_done();
    $display("Comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic send(elem_s e);
    logic r;
    int n;
    n = 0;
    in_elem_i <= e;
    in_valid_i <= 1'b1;
    do begin
      @(negedge core_clk_i);
      r = in_ready_o;
      @(posedge core_clk_i);
      if (++n > 200) begin
        fail_count++;
        test_done();
      end
    end while (r !== 1'b1);
    model(e);
  endtask

  task automatic drain(string name);
    int n;
    in_valid_i <= 1'b0;
    for (n = 0; n < 500 && (expq.size() != 0 || out_valid_o !== 1'b0); n++) @(posedge core_clk_i);
    if (n == 500) begin
      fail_count++;
      test_done();
    end
    repeat (2) @(posedge core_clk_i);
    `CHK(rs_count_o, 4'(stk.size()))
    `CHK(spec_count_o, 5'(spec))
    $display("Test %s done", name);
  endtask

  function automatic elem_s mk(elem_kind_e k, logic [63:0] a, logic bl, logic ind, logic fe);
    elem_s e;
    e = '0;
    e.kind = k;
    e.ent.addr = a;
    e.size = 4'h4;
    e.is_bl = bl;
    e.atom_e = bl;
    e.is_ind = ind;
    e.final_e = fe;
    return e;
  endfunction

  initial begin
    elem_s e;
    nrst_i = 1'b0;
    rse = 1'b1;
    max_spec = 5'h04;
    in_valid_i = 1'b0;
    in_elem_i = '0;
    stall = 1'b0;
    hist = '{default: '0};
    void'($urandom(82));
    repeat (16) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    @(posedge core_clk_i);
    // Stack overflow, pops in order, dropped oldest entry
    for (int i = 0; i < 4; i++) send(mk(EK_P0, 64'h3000 + 64'h100 * i, 1'b1, 1'b0, 1'b1));
    foreach (pool[i]) send(mk(EK_P0, 64'h3304 - 64'h100 * i, 1'b0, 1'b1, 1'b1));
    send(mk(EK_COMMIT, 64'h0, 1'b0, 1'b0, 1'b0));
    drain("stack");
    // Speculation limit and silent commits
    send(mk(EK_INFO, 64'h0, 1'b0, 1'b0, 1'b0));
    repeat (6) send(mk(EK_P0, 64'h10, 1'b0, 1'b0, 1'b0));
    repeat (6) send(mk(EK_COMMIT, 64'h0, 1'b0, 1'b0, 1'b0));
    send(mk(EK_TGT, 64'h0, 1'b0, 1'b0, 1'b0));
    drain("commit");
    // Random traffic with a stalling consumer
    stall <= 1'b1;
    for (int i = 0; i < 600; i++) begin
      e = '0;
      e = elem_s'({$urandom, $urandom, $urandom});
      e.kind = elem_kind_e'($urandom % 11);
      e.ent.addr = pool[$urandom % 4];
      e.ent.isa = 2'($urandom % 2);
      e.size = 4'h4;
      e.ent.addr = e.is_bl ? e.ent.addr - 64'h4 : e.ent.addr;
      rse <= 1'($urandom % 4 != 0);
      send(e);
    end
    drain("random");
    test_done();
  end
endmodule // trace_address_compression_tb_top
